//--- inc/rpc_pkg.sv
// Shared constants of the prescaler, countdown and test-mode block.
// Assumes a 10 MHz system clock from which the 32.768 kHz time base is derived.
package rpc_pkg;

    // Clock rates
    localparam int unsigned SYS_HZ = 10000000;
    localparam int unsigned OSC_HZ = 32768;
    localparam int          NCO_W  = 24;
    localparam logic [NCO_W-1:0] NCO_STEP = NCO_W'(OSC_HZ);
    localparam logic [NCO_W-1:0] NCO_MOD  = NCO_W'(SYS_HZ);
    localparam logic [NCO_W-1:0] NCO_HALF = NCO_W'(SYS_HZ / 2);

    // Divider chain
    localparam int STAGES    = 15;
    localparam int TEST_LSB  = 9;
    localparam int TAP_1K    = 4;
    localparam int TAP_32    = 9;
    localparam int TAP_1HZ   = 14;
    localparam int LOW_KEPT  = 2;

    // First increment after hold release, in microseconds, and its cycle figures
    localparam longint FIRST_INC_MIN_US = 507813;
    localparam longint FIRST_INC_MAX_US = 507935;
    localparam longint FIRST_MIN_TICKS  =
        (FIRST_INC_MIN_US * OSC_HZ + 64'd999999) / 64'd1000000;
    localparam longint HALF_SEC_TICKS   = 16384;
    localparam longint LOW_PHASE_MAX    = 3;
    localparam int     GAP_W            = 9;
    localparam logic [GAP_W-1:0] RELEASE_GAP =
        GAP_W'(FIRST_MIN_TICKS - HALF_SEC_TICKS + LOW_PHASE_MAX);

    // Register offsets
    localparam logic [3:0] ADDR_CTRL1   = 4'h0;
    localparam logic [3:0] ADDR_CTRL2   = 4'h1;
    localparam logic [3:0] ADDR_SECONDS = 4'h2;
    localparam logic [3:0] ADDR_CLOCK_OUTPUT_PIN  = 4'hd;
    localparam logic [3:0] ADDR_TCTRL   = 4'he;
    localparam logic [3:0] ADDR_TVALUE  = 4'hf;

    // Field positions
    localparam int CTRL1_TEST_BIT  = 7;
    localparam int CTRL1_HOLD_BIT  = 5;
    localparam int CTRL1_TESTC_BIT = 3;
    localparam int CTRL2_TITP_BIT  = 4;
    localparam int CTRL2_DONE_BIT  = 2;
    localparam int CTRL2_TIE_BIT   = 0;
    localparam int CLOCK_OUTPUT_PIN_EN_BIT   = 7;
    localparam int TCTRL_RUN_BIT   = 7;

    // Values after reset, and seconds per minute
    localparam logic       RST_TESTC   = 1'b1;
    localparam logic       RST_CLK_EN  = 1'b1;
    localparam logic [1:0] RST_CLK_SEL = 2'h0;
    localparam logic       RST_RUN     = 1'b0;
    localparam logic [1:0] RST_SRC_SEL = 2'h3;
    localparam int         SEC_PER_MIN = 60;

    typedef enum logic [1:0] {
        RPC_SRC_4096,
        RPC_SRC_64,
        RPC_SRC_1,
        RPC_SRC_60TH
    } rpc_src_e;

    typedef enum logic [1:0] {
        RPC_OUT_32K,
        RPC_OUT_1K,
        RPC_OUT_32,
        RPC_OUT_1
    } rpc_out_e;

endpackage

//--- inc/rpc_tick_if.sv
// Tick enables passed from the divider chain to the countdown.
// Each tick is a one-cycle pulse on the system clock.
`timescale 1ns/1ns
interface rpc_tick_if;
    logic tick_4096;
    logic tick_64;
    logic tick_1;

    modport src (output tick_4096, output tick_64, output tick_1);
    modport dst (input tick_4096, input tick_64, input tick_1);
endinterface

//--- logic/rpc_prescaler.sv
// Fifteen-stage divider of the 32.768 kHz time base, with hold and external-tick mode.
// Assumes osc_tick_i is a one-cycle pulse at 32.768 kHz and ext_edge_i a rising-edge pulse.
`timescale 1ns/1ns
module rpc_prescaler
    import rpc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              osc_tick_i,
    input  wire logic              hold_i,
    input  wire logic              test_mode_i,
    input  wire logic              ext_edge_i,
    output logic [STAGES-1:0]      stage_o,
    rpc_tick_if.src                ticks
);
    logic [STAGES-1:0] stage;
    logic [STAGES-1:0] next_stage;
    logic [GAP_W-1:0]  gap_cnt;
    logic              hold_q;

    always_comb begin
        next_stage = stage;
        if (test_mode_i) begin
            if (ext_edge_i) begin
                next_stage[STAGES-1:TEST_LSB] = stage[STAGES-1:TEST_LSB] + 6'h01;
            end
            if (osc_tick_i) begin
                next_stage[1:0] = stage[1:0] + 2'h1;
            end
        end else if (osc_tick_i) begin
            if (hold_i || gap_cnt != '0) begin
                next_stage = {13'h0000, stage[1:0] + 2'h1};
            end else begin
                next_stage = stage + 15'h0001;
            end
        end
        if (hold_i) begin
            next_stage[STAGES-1:LOW_KEPT] = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage <= '0;
        end else begin
            stage <= next_stage;
        end
    end

    // Upper stages wait out the release gap so the first second lands in its window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_q  <= 1'b0;
            gap_cnt <= '0;
        end else begin
            hold_q <= hold_i;
            if (hold_q && !hold_i && !test_mode_i) begin
                gap_cnt <= RELEASE_GAP;
            end else if (hold_i || test_mode_i) begin
                gap_cnt <= '0;
            end else if (osc_tick_i && gap_cnt != '0) begin
                gap_cnt <= gap_cnt - 9'h001;
            end
        end
    end

    assign stage_o         = stage;
    // Seconds advance on the 0-to-1 step of the top stage only
    assign ticks.tick_1    = !stage[STAGES-1] && next_stage[STAGES-1];
    assign ticks.tick_64   = test_mode_i ? (ext_edge_i && !hold_i)
                           : (osc_tick_i && !hold_i && gap_cnt == '0
                              && stage[TEST_LSB-1:0] == 9'h1ff);
    assign ticks.tick_4096 = osc_tick_i && !hold_i && gap_cnt == '0
                           && stage[2:0] == 3'h7;
endmodule

//--- logic/rpc_countdown.sv
// Eight-bit binary countdown with selectable source and automatic reload.
// Assumes the tick enables are one-cycle pulses; the minute source is built here.
`timescale 1ns/1ns
module rpc_countdown
    import rpc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    rpc_tick_if.dst         ticks,
    input  wire logic       run_i,
    input  wire rpc_src_e   src_sel_i,
    input  wire logic       load_i,
    input  wire logic [7:0] load_value_i,
    output logic [7:0]      count_o,
    output logic            done_o
);
    logic [7:0] count;
    logic [7:0] reload;
    logic [5:0] sec_div;
    logic       tick_60th;
    logic       src_tick;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_div <= '0;
        end else if (ticks.tick_1) begin
            sec_div <= (sec_div == 6'(SEC_PER_MIN - 1)) ? 6'h00 : sec_div + 6'h01;
        end
    end
    assign tick_60th = ticks.tick_1 && sec_div == 6'(SEC_PER_MIN - 1);

    always_comb begin
        case (src_sel_i)
            RPC_SRC_4096: src_tick = ticks.tick_4096;
            RPC_SRC_64:   src_tick = ticks.tick_64;
            RPC_SRC_1:    src_tick = ticks.tick_1;
            RPC_SRC_60TH: src_tick = tick_60th;
            default:      src_tick = 1'b0;
        endcase
    end

    // A zero reload never expires: a zero-length period has no meaning
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count  <= '0;
            reload <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (load_i) begin
                count  <= load_value_i;
                reload <= load_value_i;
            end else if (run_i && src_tick && count != '0) begin
                if (count == 8'h01) begin
                    count  <= reload;
                    done_o <= 1'b1;
                end else begin
                    count <= count - 8'h01;
                end
            end
        end
    end

    assign count_o = count;
endmodule

//--- logic/rpc_top.sv
// Time base, divider hold, external-tick test mode and countdown of the clock/calendar.
// Assumes a register access port driven by the serial slave; inputs are synchronous.
//
// Functional notes
// - Countdown is an 8-bit binary count 00h..FFh; reads return the live count.
// - Countdown period is loaded value divided by source clock frequency.
// - Countdown runs only while its run-enable bit is set.
// - Source-select field picks the clock that decrements the countdown.
// - Countdown interrupt enable and mode live in the second control register.
// - External-tick test bit turns the clock output pin into an input.
// - In test mode pin edges replace 64 Hz; 64 edges make one second.
// - A six-stage divider reduces 64 Hz to 1 Hz for the seconds counter.
// - Hold bit forces prescaler stages two to fourteen to zero until cleared.
// - In test mode, first second after release takes 32 edges, then 64.
// - Test mode entry is unsynchronised; prescaler state at entry is arbitrary.
// - Hold keeps stages two to fourteen reset; time registers stay frozen.
// - Hold keeps 32.768 kHz output but stops 1.024 kHz, 32 Hz and 1 Hz.
// - Two lowest stages ignore hold, so restart varies by one 8.192 kHz cycle.
// - Lowest divider stage runs directly from the 32.768 kHz time base.
// - Seconds advance on each 0-to-1 step of stage fourteen.
// - First second after release comes 0.507813 s to 0.507935 s later.
// - Countdown flag sets on every expiry and clears only by host write.
// - Timer config: bit 7 run enable, bits 1..0 pick 4096, 64, 1, 1/60 Hz.
`timescale 1ns/1ns
module rpc_top
    import rpc_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic [3:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic [7:0]      reg_rdata_o,
    input  wire logic       clock_output_pin_i,
    output logic            clock_output_pin_o,
    output logic            clock_output_pin_oe_o,
    output logic            countdown_int_o,
    output logic            seconds_tick_o
);
    logic              rst_meta_n;
    logic              rst_n;
    logic [NCO_W-1:0]  nco_acc;
    logic [NCO_W:0]    nco_sum;
    logic              osc_tick;
    logic              osc_level;
    logic              external_tick_test_mode;
    logic              hold;
    logic              testc;
    logic              int_mode_pulse;
    logic              countdown_done_flag;
    logic              int_enable;
    logic              clk_out_en;
    rpc_out_e          clk_out_sel;
    logic              countdown_run_enable;
    rpc_src_e          countdown_source_select;
    logic [6:0]        seconds_bcd;
    logic              pin_q;
    logic              ext_edge;
    logic [STAGES-1:0] stage;
    logic [7:0]        count;
    logic              count_done;
    logic              clk_sel_level;
    logic              wr_ctrl1;
    logic              wr_ctrl2;
    logic              wr_sec;

    rpc_tick_if ticks ();

    // Reset release through two flops
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // 32.768 kHz enable from a phase accumulator; jitter is one system cycle
    assign nco_sum = {1'b0, nco_acc} + {1'b0, NCO_STEP};
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            nco_acc  <= '0;
            osc_tick <= 1'b0;
        end else if (nco_sum >= {1'b0, NCO_MOD}) begin
            nco_acc  <= NCO_W'(nco_sum - {1'b0, NCO_MOD});
            osc_tick <= 1'b1;
        end else begin
            nco_acc  <= nco_sum[NCO_W-1:0];
            osc_tick <= 1'b0;
        end
    end
    assign osc_level = nco_acc >= NCO_HALF;

    assign wr_ctrl1 = reg_wr_i && reg_addr_i == ADDR_CTRL1;
    assign wr_ctrl2 = reg_wr_i && reg_addr_i == ADDR_CTRL2;
    assign wr_sec   = reg_wr_i && reg_addr_i == ADDR_SECONDS;

    // First control register: test select, hold, override guard
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            external_tick_test_mode <= 1'b0;
            hold                    <= 1'b0;
            testc                   <= RST_TESTC;
        end else if (wr_ctrl1) begin
            external_tick_test_mode <= reg_wdata_i[CTRL1_TEST_BIT];
            hold                    <= reg_wdata_i[CTRL1_HOLD_BIT];
            testc                   <= reg_wdata_i[CTRL1_TESTC_BIT];
        end
    end

    // Second control register: countdown interrupt enable and mode
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            int_mode_pulse <= 1'b0;
            int_enable     <= 1'b0;
        end else if (wr_ctrl2) begin
            int_mode_pulse <= reg_wdata_i[CTRL2_TITP_BIT];
            int_enable     <= reg_wdata_i[CTRL2_TIE_BIT];
        end
    end

    // Done flag: a fresh expiry beats a simultaneous clear; writing one leaves it alone
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            countdown_done_flag <= 1'b0;
        end else if (count_done) begin
            countdown_done_flag <= 1'b1;
        end else if (wr_ctrl2 && !reg_wdata_i[CTRL2_DONE_BIT]) begin
            countdown_done_flag <= 1'b0;
        end
    end

    // Clock output and countdown configuration registers
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clk_out_en  <= RST_CLK_EN;
            clk_out_sel <= rpc_out_e'(RST_CLK_SEL);
        end else if (reg_wr_i && reg_addr_i == ADDR_CLOCK_OUTPUT_PIN) begin
            clk_out_en  <= reg_wdata_i[CLOCK_OUTPUT_PIN_EN_BIT];
            clk_out_sel <= rpc_out_e'(reg_wdata_i[1:0]);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            countdown_run_enable    <= RST_RUN;
            countdown_source_select <= rpc_src_e'(RST_SRC_SEL);
        end else if (reg_wr_i && reg_addr_i == ADDR_TCTRL) begin
            countdown_run_enable    <= reg_wdata_i[TCTRL_RUN_BIT];
            countdown_source_select <= rpc_src_e'(reg_wdata_i[1:0]);
        end
    end

    // Seconds in BCD; writable while held, advances only on the 1 Hz tick
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            seconds_bcd <= '0;
        end else if (wr_sec) begin
            seconds_bcd <= reg_wdata_i[6:0];
        end else if (ticks.tick_1) begin
            if (seconds_bcd[3:0] == 4'h9) begin
                seconds_bcd[3:0] <= 4'h0;
                seconds_bcd[6:4] <= (seconds_bcd[6:4] == 3'h5) ? 3'h0
                                  : seconds_bcd[6:4] + 3'h1;
            end else begin
                seconds_bcd[3:0] <= seconds_bcd[3:0] + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            seconds_tick_o <= 1'b0;
        end else begin
            seconds_tick_o <= ticks.tick_1;
        end
    end

    // Pin edge detect: the pin is taken as synchronous to the system clock
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= clock_output_pin_i;
        end
    end
    assign ext_edge = external_tick_test_mode && clock_output_pin_i && !pin_q;

    rpc_prescaler u_prescaler (
        .clk_i       (sys_clk_i),
        .rst_n_i     (rst_n),
        .osc_tick_i  (osc_tick),
        .hold_i      (hold),
        .test_mode_i (external_tick_test_mode),
        .ext_edge_i  (ext_edge),
        .stage_o     (stage),
        .ticks       (ticks.src)
    );

    rpc_countdown u_countdown (
        .clk_i        (sys_clk_i),
        .rst_n_i      (rst_n),
        .ticks        (ticks.dst),
        .run_i        (countdown_run_enable),
        .src_sel_i    (countdown_source_select),
        .load_i       (reg_wr_i && reg_addr_i == ADDR_TVALUE),
        .load_value_i (reg_wdata_i),
        .count_o      (count),
        .done_o       (count_done)
    );

    // Divided taps are stopped by hold because their stages are cleared
    always_comb begin
        case (clk_out_sel)
            RPC_OUT_32K: clk_sel_level = osc_level;
            RPC_OUT_1K:  clk_sel_level = stage[TAP_1K];
            RPC_OUT_32:  clk_sel_level = stage[TAP_32];
            RPC_OUT_1:   clk_sel_level = stage[TAP_1HZ];
            default:     clk_sel_level = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clock_output_pin_o    <= 1'b0;
            clock_output_pin_oe_o <= 1'b0;
        end else begin
            clock_output_pin_o    <= clk_sel_level;
            clock_output_pin_oe_o <= clk_out_en && !external_tick_test_mode;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            countdown_int_o <= 1'b0;
        end else begin
            countdown_int_o <= int_enable && (int_mode_pulse ? count_done
                                              : (countdown_done_flag || count_done));
        end
    end

    // Registered read port; unmapped offsets read zero
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= '0;
        end else begin
            case (reg_addr_i)
                ADDR_CTRL1:   reg_rdata_o <= {external_tick_test_mode, 1'b0, hold, 1'b0,
                                              testc, 3'h0};
                ADDR_CTRL2:   reg_rdata_o <= {3'h0, int_mode_pulse, 1'b0,
                                              countdown_done_flag, 1'b0, int_enable};
                ADDR_SECONDS: reg_rdata_o <= {1'b0, seconds_bcd};
                ADDR_CLOCK_OUTPUT_PIN:  reg_rdata_o <= {clk_out_en, 5'h00, clk_out_sel};
                ADDR_TCTRL:   reg_rdata_o <= {countdown_run_enable, 5'h00,
                                              countdown_source_select};
                ADDR_TVALUE:  reg_rdata_o <= count;
                default:      reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

//--- verification/rpc_checker.sv
// Pin-level assertions for rpc_top.
// Assumes single-cycle write strobes and a bench that drives the pin in test mode.
`timescale 1ns/1ns
module rpc_checker
    import rpc_pkg::*;
(
    input wire logic       sys_clk_i,
    input wire logic       rstn_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       clock_output_pin_i,
    input wire logic       clock_output_pin_o,
    input wire logic       clock_output_pin_oe_o,
    input wire logic       countdown_int_o,
    input wire logic       seconds_tick_o
);
    logic        hold_q, test_q, run_q, pulse_q, ie_q, synced_q, pin_q;
    logic [1:0]  sel_q;
    logic [15:0] edge_cnt;
    wire         ctrl2_wr = reg_wr_i && reg_addr_i == ADDR_CTRL2;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    // Shadow of control bits, taken from the write strobes
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {hold_q, test_q, run_q, pulse_q, ie_q, sel_q} <= '0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == ADDR_CTRL1)
                {test_q, hold_q} <= {reg_wdata_i[7], reg_wdata_i[5]};
            if (ctrl2_wr)
                {pulse_q, ie_q} <= {reg_wdata_i[4], reg_wdata_i[0]};
            if (reg_addr_i == ADDR_CLOCK_OUTPUT_PIN)
                sel_q <= reg_wdata_i[1:0];
            if (reg_addr_i == ADDR_TCTRL)
                run_q <= reg_wdata_i[7];
        end
    end

    // Pin edges since hold release; only trusted once a hold was seen in test mode
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {pin_q, synced_q, edge_cnt} <= '0;
        end else begin
            pin_q <= clock_output_pin_i;
            synced_q <= test_q & (synced_q | hold_q);
            if (hold_q)
                edge_cnt <= '0;
            else if (clock_output_pin_i & ~pin_q)
                edge_cnt <= edge_cnt + 16'h1;
        end
    end

    AST_COUNT_LOAD:
    assert property ((reg_wr_i && reg_addr_i == ADDR_TVALUE) ##1
        (reg_addr_i == ADDR_TVALUE && !reg_wr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("count read differs from the value written");
    AST_RUN_HALT:
    assert property (!run_q && !$past(run_q, 3) && !$past(reg_wr_i) && !$past(reg_wr_i, 2)
        && $past(reg_addr_i) == ADDR_TVALUE && $past(reg_addr_i, 2) == ADDR_TVALUE
        |-> $stable(reg_rdata_o)) else $error("count moved while halted");
    AST_INT_EN:
    assert property ($rose(countdown_int_o) |-> ie_q || $past(ie_q))
        else $error("interrupt rose while disabled");
    AST_TEST_OE:
    assert property ((reg_wr_i && reg_addr_i == ADDR_CTRL1 && reg_wdata_i[7]) ##1 !reg_wr_i
        |=> !clock_output_pin_oe_o) else $error("pin still driven in test mode");
    AST_TEST_EDGES:
    assert property (synced_q && !hold_q && seconds_tick_o |-> edge_cnt[5:0] == 6'h20)
        else $error("seconds advanced off the edge count");
    AST_HOLD_NO_SEC:
    assert property (hold_q && $past(hold_q, 2) |-> !seconds_tick_o)
        else $error("seconds advanced during hold");
    AST_HOLD_OUT:
    assert property (hold_q && $past(hold_q, 3) && sel_q != 2'h0 && $past(sel_q, 3) == sel_q
        |-> $stable(clock_output_pin_o)) else $error("divided output runs during hold");
    AST_FLAG_STICKY:
    assert property ($fell(countdown_int_o) && !pulse_q && !$past(pulse_q)
        |-> $past(ctrl2_wr, 2)) else $error("flag cleared without a write");

    cover property (seconds_tick_o);
    cover property ($fell(countdown_int_o));
    cover property ($fell(clock_output_pin_oe_o));
endmodule

bind rpc_top rpc_checker u_chk (.sys_clk_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rdata_o, .clock_output_pin_i, .clock_output_pin_o, .clock_output_pin_oe_o,
    .countdown_int_o, .seconds_tick_o);

//--- verification/rpc_pin_host.sv
// Board-side source of edges for the clock output pin in test mode.
// Assumes the bench resolves the pin from the design's output enable.
`timescale 1ns/1ns
module rpc_pin_host (
    input  wire logic clk_i,
    output logic      pin_o
);
    initial pin_o = 1'b0;
    // Three cycles per level keeps each level above the two-cycle minimum
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (3) @(negedge clk_i);
            pin_o = 1'b1;
            repeat (3) @(negedge clk_i);
            pin_o = 1'b0;
        end
    endtask
endmodule

//--- verification/tb_rtc_prescaler_countdown_testmode.sv
// Self-checking bench: register table, countdown, hold and test-mode seconds.
// Assumes rpc_checker is bound into rpc_top and rpc_pin_host drives the pin.
`timescale 1ns/1ns
module tb_rtc_prescaler_countdown_testmode
    import rpc_pkg::*;
;
    localparam int TICK = SYS_HZ / 4096;
    logic        sys_clk, rstn, wr, pin_i, pin_o, oe, int_o, sec_tick, drv;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, v;
    int          error_cnt, num_checks, n;
    // {offset, write, data, expected read}
    logic [20:0] rows [8] = '{{4'hf, 1'b0, 8'h00, 8'h00}, {4'he, 1'b0, 8'h00, 8'h03},
        {4'h0, 1'b0, 8'h00, 8'h08}, {4'h3, 1'b1, 8'h5a, 8'h00}, {4'hf, 1'b1, 8'hff, 8'hff},
        {4'hf, 1'b1, 8'h80, 8'h80}, {4'he, 1'b1, 8'h02, 8'h02}, {4'he, 1'b1, 8'h03, 8'h03}};

    assign pin_i = oe ? pin_o : drv;
    rpc_top DUT (.sys_clk_i(sys_clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .clock_output_pin_i(pin_i),
        .clock_output_pin_o(pin_o), .clock_output_pin_oe_o(oe), .countdown_int_o(int_o),
        .seconds_tick_o(sec_tick));
    rpc_pin_host u_pin (.clk_i(sys_clk), .pin_o(drv));

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    task automatic chkv(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            error_cnt++;
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {addr, wr, wdata} = {a, 1'b1, d};
        @(negedge sys_clk);
        wr = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        addr = a;
        @(negedge sys_clk);
        d = rdata;
    endtask
    task automatic chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chkv("register", exp, d);
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // The tests need about 30000 cycles; twice that means a hang
    initial begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        {rstn, addr, wr, wdata, error_cnt, num_checks} = '0;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        foreach (rows[i]) begin
            if (rows[i][16])
                wreg(rows[i][20:17], rows[i][15:8]);
            chk(rows[i][20:17], rows[i][7:0]);
        end
        $display("register table done");
        wreg(ADDR_CTRL2, 8'h01);
        wreg(ADDR_TVALUE, 8'h02);
        wreg(ADDR_TCTRL, 8'h80);
        n = 0;
        while (int_o !== 1'b1 && n < 3 * TICK) begin
            @(negedge sys_clk);
            n++;
        end
        chkv("expiry time", 8'h1, {7'h0, n >= TICK && n <= 2 * TICK + 8});
        chk(ADDR_TVALUE, 8'h02);
        chk(ADDR_CTRL2, 8'h05);
        repeat (2 * TICK + 10) @(negedge sys_clk);
        chkv("interrupt", 8'h1, {7'h0, int_o});
        wreg(ADDR_CTRL2, 8'h01);
        repeat (3) @(negedge sys_clk);
        chkv("interrupt", 8'h0, {7'h0, int_o});
        wreg(ADDR_TCTRL, 8'h03);
        rd(ADDR_TVALUE, v);
        chk(ADDR_TVALUE, v);
        repeat (3 * TICK) @(negedge sys_clk);
        chk(ADDR_TVALUE, v);
        $display("countdown test done");
        wreg(ADDR_CTRL1, 8'h28);
        wreg(ADDR_SECONDS, 8'h45);
        n = 0;
        v[0] = pin_o;
        repeat (1000) begin
            @(negedge sys_clk);
            n += int'(pin_o !== v[0]);
            v[0] = pin_o;
        end
        chkv("fast output toggles", 8'h1, {7'h0, n >= 4});
        wreg(ADDR_CLOCK_OUTPUT_PIN, 8'h81);
        repeat (3 * TICK) @(negedge sys_clk);
        chk(ADDR_SECONDS, 8'h45);
        wreg(ADDR_CLOCK_OUTPUT_PIN, 8'h80);
        wreg(ADDR_CTRL1, 8'h08);
        $display("hold test done");
        wreg(ADDR_CTRL1, 8'h88);
        repeat (2) @(negedge sys_clk);
        chkv("pin enable", 8'h0, {7'h0, oe});
        wreg(ADDR_CTRL1, 8'ha8);
        u_pin.pulses(64);
        chk(ADDR_SECONDS, 8'h45);
        wreg(ADDR_CTRL1, 8'h88);
        wreg(ADDR_SECONDS, 8'h00);
        wreg(ADDR_TVALUE, 8'h05);
        wreg(ADDR_TCTRL, 8'h81);
        u_pin.pulses(31);
        chk(ADDR_SECONDS, 8'h00);
        u_pin.pulses(1);
        chk(ADDR_SECONDS, 8'h01);
        u_pin.pulses(64);
        chk(ADDR_SECONDS, 8'h02);
        chk(ADDR_TVALUE, 8'h04);
        wreg(ADDR_CTRL2, 8'h11);
        u_pin.pulses(4);
        chk(ADDR_CTRL2, 8'h15);
        chkv("pulsed interrupt", 8'h0, {7'h0, int_o});
        $display("test mode done");
        @(negedge sys_clk);
        rstn = 1'b0;
        @(negedge sys_clk);
        chkv("read in reset", 8'h00, rdata);
        @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(ADDR_CTRL1, 8'h08);
        chk(ADDR_TCTRL, 8'h03);
        chkv("pin enable", 8'h1, {7'h0, oe});
        $display("reset test done");
        print_verdict();
    end
endmodule
